/* src/boe_pkg.sv */
// Shared constants and types of the byte-operation execution core
package boe_pkg;
    localparam int unsigned REG_ADDR_W = 8;
    localparam int unsigned REG_DATA_W = 32;
    localparam int unsigned INSN_W = 16;
    localparam int unsigned PC_W = 16;
    localparam int unsigned FILE_ADDR_W = 12;
    localparam int unsigned PTR_W = 12;
    localparam int unsigned NUM_PTR = 3;
    localparam int unsigned NUM_PHASES = 4;

    // Register map, byte addresses on the register port
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_ACC = 8'h04;
    localparam logic [7:0] OFF_BANK = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0c;
    localparam logic [7:0] OFF_PC = 8'h10;
    localparam logic [7:0] OFF_PTR0 = 8'h14;
    localparam logic [7:0] OFF_PTR1 = 8'h18;
    localparam logic [7:0] OFF_PTR2 = 8'h1c;

    // Field positions
    localparam int unsigned CTRL_RUN_BIT = 0;
    localparam int unsigned STAT_Z_BIT = 0;
    localparam int unsigned STAT_N_BIT = 1;
    localparam int unsigned STAT_MODE_LSB = 4;
    localparam int unsigned DEST_BIT = 9;
    localparam int unsigned BANKED_BIT = 8;

    // Reset values
    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam logic [15:0] INSN_NOP = 16'h0000;
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [7:0] BANK_RESET = 8'h00;
    localparam logic [3:0] PHASE_RESET = 4'h1;

    // Access bank: low half of bank 0 and high half of the top bank
    localparam logic [7:0] ACCESS_SPLIT = 8'h80;
    localparam logic [3:0] ACCESS_LO_BANK = 4'h0;
    localparam logic [3:0] ACCESS_HI_BANK = 4'hf;

    // Opcode patterns
    localparam logic [7:0] OPC_OR_LIT = 8'h09;
    localparam logic [5:0] OPC_OR_FILE = 6'h04;
    localparam logic [5:0] OPC_MOVE_FILE = 6'h14;
    localparam logic [5:0] OPC_INC_SKIP_NZ = 6'h12;
    localparam logic [5:0] OPC_INC_SKIP_Z = 6'h0f;
    localparam logic [9:0] OPC_LDPTR_FIRST = 10'h3b8;
    localparam logic [7:0] OPC_LDPTR_SECOND = 8'hf0;
    localparam logic [3:0] OPC_TWO_WORD_MOVE = 4'hc;
    localparam logic [5:0] OPC_TWO_WORD_FLOW = 6'h3b;

    typedef enum logic [2:0] {
        BOE_MODE_EXEC = 3'b001,
        BOE_MODE_SKIP = 3'b010,
        BOE_MODE_PTR2 = 3'b100
    } boe_mode_t;

    typedef enum logic [5:0] {
        BOE_OP_NONE = 6'b000001,
        BOE_OP_INC_SKIP_NZ = 6'b000010,
        BOE_OP_INC_SKIP_Z = 6'b000100,
        BOE_OP_OR_LIT = 6'b001000,
        BOE_OP_OR_FILE = 6'b010000,
        BOE_OP_MOVE_FILE = 6'b100000
    } boe_op_t;

    typedef struct packed {
        logic [FILE_ADDR_W-1:0] addr;
        logic [7:0] wdata;
        logic we;
    } boe_dmem_t;

    typedef struct packed {
        logic [PC_W-1:0] pc;
        logic [INSN_W-1:0] ir;
        boe_mode_t mode;
        boe_op_t op;
        logic [1:0] ptr_sel;
        logic [7:0] operand;
        logic [7:0] result;
        logic [7:0] acc;
        logic [7:0] bank;
        logic flag_n;
        logic flag_z;
        logic run;
        logic [NUM_PTR-1:0][PTR_W-1:0] ptr;
        boe_dmem_t dmem;
        logic [REG_DATA_W-1:0] rdata;
    } boe_state_t;

    typedef struct packed {
        logic [NUM_PHASES-1:0] ph;
    } boe_phase_state_t;
endpackage : boe_pkg

/* src/boe_phase_gen.sv */
// Four-phase sequencer: one pulse per phase, halts only at a cycle boundary
`timescale 1ns/100ps
`default_nettype none
module boe_phase_gen #(
    parameter int unsigned PHASES = boe_pkg::NUM_PHASES
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic run,
    output logic [PHASES-1:0] phase
);
    // The core decodes exactly four one-hot phases, so refuse any other count
    if (PHASES != boe_pkg::NUM_PHASES) begin : g_bad_phases
        $error("boe_phase_gen supports exactly four phases");
    end

    boe_pkg::boe_phase_state_t s;
    boe_pkg::boe_phase_state_t next_s;
    logic advance;

    // A started cycle always runs to its end so no instruction is cut in half
    assign advance = run | ~s.ph[0];
    assign phase = advance ? s.ph : '0;

    always_comb begin
        next_s = s;
        if (advance) begin
            next_s.ph = {s.ph[PHASES-2:0], s.ph[PHASES-1]};
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            s.ph <= boe_pkg::PHASE_RESET;
        end else begin
            s <= next_s;
        end
    end
endmodule : boe_phase_gen
`default_nettype wire

/* src/boe_core.sv */
// Execution core for the increment-skip, OR, load-pointer and move-file ops
//
// Overview of operation
// - Skip costs one cycle, two if skipping, three over a two-word instruction.
// - Increment-skip-if-nonzero adds one, writes destination, skips when result nonzero.
// - OR-literal ORs accumulator with literal into accumulator, updates N and Z.
// - OR-with-file ORs accumulator with file into destination, updates N and Z.
// - Destination bit zero writes accumulator; one writes back the file register.
// - Bank bit zero uses access bank; one uses the bank choice register.
// - Load-pointer puts a 12-bit literal in pointer 0 to 2 over two words.
// - Move-file copies file register to destination and updates N and Z.
// - Eight-bit file address reaches any byte of a 256-byte bank.
// - A skip discards the prefetched instruction and runs a no-operation instead.
//
// The register addresses and the address-and-strobe port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module boe_core (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [boe_pkg::REG_ADDR_W-1:0] reg_addr,
    input wire logic [boe_pkg::REG_DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [boe_pkg::REG_DATA_W-1:0] reg_rdata,
    output logic [boe_pkg::PC_W-1:0] prog_addr,
    input wire logic [boe_pkg::INSN_W-1:0] prog_word,
    output var boe_pkg::boe_dmem_t dmem,
    input wire logic [7:0] dmem_rdata
);
    boe_pkg::boe_state_t s;
    boe_pkg::boe_state_t next_s;
    logic [boe_pkg::NUM_PHASES-1:0] phase;

    boe_phase_gen #(
        .PHASES(boe_pkg::NUM_PHASES)
    ) u_phase (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .run(s.run),
        .phase(phase)
    );

    assign reg_rdata = s.rdata;
    assign prog_addr = s.pc;
    assign dmem = s.dmem;

    function automatic boe_pkg::boe_op_t decode_op(input logic [15:0] w);
        boe_pkg::boe_op_t op;
        op = boe_pkg::BOE_OP_NONE;
        if (w[15:8] == boe_pkg::OPC_OR_LIT) begin
            op = boe_pkg::BOE_OP_OR_LIT;
        end else if (w[15:10] == boe_pkg::OPC_OR_FILE) begin
            op = boe_pkg::BOE_OP_OR_FILE;
        end else if (w[15:10] == boe_pkg::OPC_MOVE_FILE) begin
            op = boe_pkg::BOE_OP_MOVE_FILE;
        end else if (w[15:10] == boe_pkg::OPC_INC_SKIP_NZ) begin
            op = boe_pkg::BOE_OP_INC_SKIP_NZ;
        end else if (w[15:10] == boe_pkg::OPC_INC_SKIP_Z) begin
            op = boe_pkg::BOE_OP_INC_SKIP_Z;
        end
        return op;
    endfunction : decode_op

    function automatic logic is_two_word(input logic [15:0] w);
        return (w[15:12] == boe_pkg::OPC_TWO_WORD_MOVE)
            || (w[15:10] == boe_pkg::OPC_TWO_WORD_FLOW);
    endfunction : is_two_word

    function automatic logic [11:0] file_addr(input logic banked, input logic [7:0] f,
                                              input logic [7:0] bank);
        logic [3:0] hi;
        if (banked) begin
            hi = bank[3:0];
        end else if (f < boe_pkg::ACCESS_SPLIT) begin
            hi = boe_pkg::ACCESS_LO_BANK;
        end else begin
            hi = boe_pkg::ACCESS_HI_BANK;
        end
        return {hi, f};
    endfunction : file_addr

    function automatic logic is_file_op(input boe_pkg::boe_op_t op);
        return op != boe_pkg::BOE_OP_NONE && op != boe_pkg::BOE_OP_OR_LIT;
    endfunction : is_file_op

    always_comb begin
        next_s = s;
        next_s.rdata = '0;

        // Register port writes; the core's own updates below take precedence
        if (reg_wr) begin
            case (reg_addr)
                boe_pkg::OFF_CTRL: next_s.run = reg_wdata[boe_pkg::CTRL_RUN_BIT];
                boe_pkg::OFF_ACC: next_s.acc = reg_wdata[7:0];
                boe_pkg::OFF_BANK: next_s.bank = reg_wdata[7:0];
                boe_pkg::OFF_PC: next_s.pc = reg_wdata[boe_pkg::PC_W-1:0];
                boe_pkg::OFF_PTR0: next_s.ptr[0] = reg_wdata[boe_pkg::PTR_W-1:0];
                boe_pkg::OFF_PTR1: next_s.ptr[1] = reg_wdata[boe_pkg::PTR_W-1:0];
                boe_pkg::OFF_PTR2: next_s.ptr[2] = reg_wdata[boe_pkg::PTR_W-1:0];
                default: begin
                end
            endcase
        end
        if (reg_rd) begin
            case (reg_addr)
                boe_pkg::OFF_CTRL: next_s.rdata[boe_pkg::CTRL_RUN_BIT] = s.run;
                boe_pkg::OFF_ACC: next_s.rdata[7:0] = s.acc;
                boe_pkg::OFF_BANK: next_s.rdata[7:0] = s.bank;
                boe_pkg::OFF_STATUS: begin
                    next_s.rdata[boe_pkg::STAT_Z_BIT] = s.flag_z;
                    next_s.rdata[boe_pkg::STAT_N_BIT] = s.flag_n;
                    next_s.rdata[boe_pkg::STAT_MODE_LSB +: 3] = s.mode;
                end
                boe_pkg::OFF_PC: next_s.rdata[boe_pkg::PC_W-1:0] = s.pc;
                boe_pkg::OFF_PTR0: next_s.rdata[boe_pkg::PTR_W-1:0] = s.ptr[0];
                boe_pkg::OFF_PTR1: next_s.rdata[boe_pkg::PTR_W-1:0] = s.ptr[1];
                boe_pkg::OFF_PTR2: next_s.rdata[boe_pkg::PTR_W-1:0] = s.ptr[2];
                default: next_s.rdata = '0;
            endcase
        end

        if (phase[0]) begin
            case (s.mode)
                boe_pkg::BOE_MODE_EXEC: next_s.op = decode_op(s.ir);
                boe_pkg::BOE_MODE_SKIP: next_s.op = boe_pkg::BOE_OP_NONE;
                boe_pkg::BOE_MODE_PTR2: next_s.op = boe_pkg::BOE_OP_NONE;
                default: next_s.op = boe_pkg::BOE_OP_NONE;
            endcase
            next_s.dmem.addr = file_addr(s.ir[boe_pkg::BANKED_BIT], s.ir[7:0], s.bank);
        end

        if (phase[1]) begin
            next_s.operand = dmem_rdata;
        end

        if (phase[2]) begin
            case (s.op)
                boe_pkg::BOE_OP_INC_SKIP_NZ: next_s.result = s.operand + 8'h01;
                boe_pkg::BOE_OP_INC_SKIP_Z: next_s.result = s.operand + 8'h01;
                boe_pkg::BOE_OP_OR_LIT: next_s.result = s.acc | s.ir[7:0];
                boe_pkg::BOE_OP_OR_FILE: next_s.result = s.acc | s.operand;
                boe_pkg::BOE_OP_MOVE_FILE: next_s.result = s.operand;
                default: next_s.result = s.result;
            endcase
            if (is_file_op(s.op) && s.ir[boe_pkg::DEST_BIT]) begin
                next_s.dmem.we = 1'b1;
                next_s.dmem.wdata = next_s.result;
            end
        end

        if (phase[3]) begin
            next_s.dmem.we = 1'b0;
            if (s.op == boe_pkg::BOE_OP_OR_LIT
                || (is_file_op(s.op) && !s.ir[boe_pkg::DEST_BIT])) begin
                next_s.acc = s.result;
            end
            if (s.op == boe_pkg::BOE_OP_OR_LIT || s.op == boe_pkg::BOE_OP_OR_FILE
                || s.op == boe_pkg::BOE_OP_MOVE_FILE) begin
                next_s.flag_n = s.result[7];
                next_s.flag_z = s.result == 8'h00;
            end
            next_s.mode = boe_pkg::BOE_MODE_EXEC;
            case (s.mode)
                boe_pkg::BOE_MODE_EXEC: begin
                    if (s.op == boe_pkg::BOE_OP_INC_SKIP_NZ && s.result != 8'h00) begin
                        next_s.mode = boe_pkg::BOE_MODE_SKIP;
                    end
                    if (s.op == boe_pkg::BOE_OP_INC_SKIP_Z && s.result == 8'h00) begin
                        next_s.mode = boe_pkg::BOE_MODE_SKIP;
                    end
                    if (s.ir[15:6] == boe_pkg::OPC_LDPTR_FIRST) begin
                        next_s.mode = boe_pkg::BOE_MODE_PTR2;
                        next_s.ptr_sel = s.ir[5:4];
                        if (s.ir[5:4] != 2'h3) begin
                            next_s.ptr[s.ir[5:4]][11:8] = s.ir[3:0];
                        end
                    end
                end
                boe_pkg::BOE_MODE_SKIP: begin
                    // two-word skip adds a third cycle
                    if (is_two_word(s.ir)) begin
                        next_s.mode = boe_pkg::BOE_MODE_SKIP;
                    end
                end
                boe_pkg::BOE_MODE_PTR2: begin
                    if (s.ir[15:8] == boe_pkg::OPC_LDPTR_SECOND && s.ptr_sel != 2'h3) begin
                        next_s.ptr[s.ptr_sel][7:0] = s.ir[7:0];
                    end
                end
                default: next_s.mode = boe_pkg::BOE_MODE_EXEC;
            endcase
            // Prefetch: the word fetched now is what a skip throws away
            next_s.ir = prog_word;
            next_s.pc = s.pc + 16'h0001;
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            s.pc <= boe_pkg::PC_RESET;
            s.ir <= boe_pkg::INSN_NOP;
            s.mode <= boe_pkg::BOE_MODE_EXEC;
            s.op <= boe_pkg::BOE_OP_NONE;
            s.ptr_sel <= 2'h0;
            s.operand <= 8'h00;
            s.result <= 8'h00;
            s.acc <= boe_pkg::ACC_RESET;
            s.bank <= boe_pkg::BANK_RESET;
            s.flag_n <= 1'b0;
            s.flag_z <= 1'b0;
            s.run <= 1'b0;
            s.ptr <= '0;
            s.dmem <= '0;
            s.rdata <= '0;
        end else begin
            s <= next_s;
        end
    end
endmodule : boe_core
`default_nettype wire

/* verif/boe_core_properties.sv */
// Port-level timing checks of the execution core
`timescale 1ns/100ps
`default_nettype none
module boe_core_properties (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic [15:0] prog_addr,
    input wire logic [15:0] prog_word,
    input wire boe_pkg::boe_dmem_t dmem,
    input wire logic [7:0] dmem_rdata
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    a_we_single_clock: assert property ($rose(dmem.we) |=> (!dmem.we) [*3])
        else $error("file write longer than one phase");
    a_addr_held_write: assert property (dmem.we |-> $stable(dmem.addr) &&
        dmem.addr == $past(dmem.addr, 2)) else $error("file address moved before write");
    a_addr_once_cycle: assert property ($changed(dmem.addr) |=> $stable(dmem.addr) [*3])
        else $error("file address changed inside a cycle");
    a_pc_single_step: assert property ($changed(prog_addr) && !$past(reg_wr) |->
        prog_addr == $past(prog_addr) + 16'h0001) else $error("fetch address jumped");
    a_pc_cycle_spacing: assert property ($changed(prog_addr) && !$past(reg_wr) |=>
        $stable(prog_addr) [*3]) else $error("fetch faster than four clocks");
    a_write_then_fetch: assert property (dmem.we |=> $changed(prog_addr))
        else $error("no fetch after destination write");
    a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data without a read");
    a_reset_quiet_state: assert property ($fell(sys_rst) |-> prog_addr == 16'h0000 &&
        dmem == '0) else $error("outputs not cleared by reset");
endmodule : boe_core_properties
bind boe_core boe_core_properties u_props (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .prog_addr(prog_addr), .prog_word(prog_word), .dmem(dmem),
    .dmem_rdata(dmem_rdata));
`default_nettype wire

/* verif/boe_mem_model.sv */
// Program and data memory seen by the core
`timescale 1ns/100ps
`default_nettype none
module boe_mem_model (
    input wire logic clk_sys,
    input wire logic [15:0] prog_addr,
    output logic [15:0] prog_word,
    input wire boe_pkg::boe_dmem_t dmem,
    output logic [7:0] dmem_rdata
);
    logic [15:0] rom [256];
    logic [7:0] ram [4096];
    initial begin
        for (int i = 0; i < 4096; i++) begin
            ram[i] = 8'h00;
        end
        for (int i = 0; i < 256; i++) begin
            rom[i] = 16'h0000;
        end
    end
    // Beyond the loaded window the fetch sees a no-operation word
    assign prog_word = (prog_addr[15:8] == 8'h00) ? rom[prog_addr[7:0]] : 16'h0000;
    assign dmem_rdata = ram[dmem.addr];
    always @(posedge clk_sys) begin
        if (dmem.we) begin
            ram[dmem.addr] <= dmem.wdata;
        end
    end
endmodule : boe_mem_model
`default_nettype wire

/* verif/boe_core_tb.sv */
// Self-checking bench of the execution core
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin mismatches++; \
    $display("wrong value at %0t: %h expected %h", $time, (a), (e)); end end
module boe_core_tb;
    typedef struct {logic mem; logic [11:0] a; logic [31:0] exp;} boe_row_t;
    logic clk_sys, sys_rst, reg_wr, reg_rd;
    logic [7:0] reg_addr, dmem_rdata;
    logic [31:0] reg_wdata, reg_rdata;
    logic [15:0] prog_addr, prog_word;
    boe_pkg::boe_dmem_t dmem;
    int mismatches = 0;
    int comparisons = 0;
    // Skipped words at 8 and 10 would change the accumulator if run
    logic [15:0] prog [14] = '{16'h099a, 16'h0935, 16'h5010, 16'h1320, 16'h4a11,
        16'h0940, 16'h4812, 16'hc000, 16'h0980, 16'h4a13, 16'h0901, 16'hee23,
        16'hf0ab, 16'h52f0};
    boe_row_t rows [14] = '{'{0, 12'h004, 32'h06}, '{0, 12'h00c, 32'h12},
        '{0, 12'h01c, 32'h3ab}, '{0, 12'h014, 32'h0}, '{0, 12'h018, 32'h0},
        '{0, 12'h008, 32'h2}, '{0, 12'h000, 32'h0}, '{1, 12'h220, 32'h33},
        '{1, 12'h011, 32'h00}, '{1, 12'h013, 32'h01}, '{1, 12'h012, 32'h05},
        '{1, 12'hff0, 32'h80}, '{1, 12'h210, 32'h55}, '{1, 12'h010, 32'h13}};
    boe_core uut (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .prog_addr(prog_addr), .prog_word(prog_word), .dmem(dmem), .dmem_rdata(dmem_rdata));
    boe_mem_model u_mem (.clk_sys(clk_sys), .prog_addr(prog_addr), .prog_word(prog_word),
        .dmem(dmem), .dmem_rdata(dmem_rdata));
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        `CHK(reg_rdata, e)
    endtask : rd
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : conclude
    initial begin
        #(20000 * 8);
        mismatches++;
        conclude();
    end
    initial begin
        sys_rst = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        repeat (6) @(posedge clk_sys);
        sys_rst <= 1'b0;
        for (int i = 0; i < 14; i++) begin
            u_mem.rom[i] = prog[i];
        end
        u_mem.ram[12'h010] = 8'h13;
        u_mem.ram[12'h210] = 8'h55;
        u_mem.ram[12'h220] = 8'h22;
        u_mem.ram[12'h011] = 8'hff;
        u_mem.ram[12'h012] = 8'h05;
        // Nonzero so a wrong access-bank half shows up in the final flags
        u_mem.ram[12'hff0] = 8'h80;
        // Reset values; status is read-only and unmapped places read zero
        wr(8'h0c, 32'hff);
        wr(8'h40, 32'hff);
        rd(8'h0c, 32'h10);
        rd(8'h40, 32'h0);
        rd(8'h04, 32'h0);
        rd(8'h10, 32'h0);
        rd(8'h14, 32'h0);
        wr(8'h08, 32'h2);
        wr(8'h00, 32'h1);
        for (int i = 0; i < 400 && prog_addr !== 16'h0010; i++) begin
            @(posedge clk_sys);
        end
        // A run that never gets there counts as a mismatch
        `CHK(prog_addr, 16'h0010)
        wr(8'h00, 32'h0);
        repeat (8) @(posedge clk_sys);
        // Rows cover OR, move, increment-skip, pointer load, bank and skip counts
        for (int i = 0; i < 14; i++) begin
            if (rows[i].mem) begin
                `CHK({24'h0, u_mem.ram[rows[i].a]}, rows[i].exp)
            end else begin
                rd(rows[i].a[7:0], rows[i].exp);
            end
        end
        // Skip-if-zero: skips once on wrap to zero, falls through on a nonzero result
        u_mem.rom[8'h20] = 16'h3c30;
        u_mem.rom[8'h21] = 16'h0902;
        u_mem.rom[8'h22] = 16'h0904;
        u_mem.rom[8'h23] = 16'h3e31;
        u_mem.rom[8'h24] = 16'h0908;
        u_mem.ram[12'h030] = 8'hff;
        wr(8'h10, 32'h20);
        wr(8'h00, 32'h1);
        for (int i = 0; i < 400 && prog_addr !== 16'h0028; i++) begin
            @(posedge clk_sys);
        end
        `CHK(prog_addr, 16'h0028)
        rd(8'h04, 32'h0c);
        `CHK(u_mem.ram[12'h031], 8'h01)
        `CHK(u_mem.ram[12'h030], 8'hff)
        // Reset while running: core halts and control, PC, accumulator, status and pointer 2 read their reset values
        @(posedge clk_sys);
        sys_rst <= 1'b1;
        repeat (3) @(posedge clk_sys);
        sys_rst <= 1'b0;
        rd(8'h00, 32'h0);
        rd(8'h10, 32'h0);
        rd(8'h04, 32'h0);
        rd(8'h0c, 32'h10);
        rd(8'h1c, 32'h0);
        conclude();
    end
endmodule : boe_core_tb
`default_nettype wire
